//--- verilog/mfio_map.svh
// Purpose: offsets, field positions, reset values of the interrupt block
// Assumes: avalon word index addressing, one 32-bit word per register
// Notes:   definitions only
`ifndef MFIO_MAP_SVH
`define MFIO_MAP_SVH

// register word indexes
`define MFIO_SER_CTL_OFS     4'h0
`define MFIO_PAR_CTL_OFS     4'h1
`define MFIO_DISK_REG_OFS    4'h2
`define MFIO_SYS_MODE_OFS    4'h3
`define MFIO_CMD_PARAM_OFS   4'h4
`define MFIO_STATE_OFS       4'h5
`define MFIO_INT_STAT_OFS    4'h6
`define MFIO_INT_MASK_OFS    4'h7

// serial control fields, channel 1 sits 8 bits above channel 0
`define MFIO_SER_IER_POS     0
`define MFIO_SER_OUT2_POS    4
`define MFIO_SER_COM_POS     5
`define MFIO_SER_CH_STRIDE   8

// parallel control fields
`define MFIO_PAR_IRQEN_POS   4
`define MFIO_PAR_BASE_POS    8
`define MFIO_PAR_XT_POS      12

// disk register fields
`define MFIO_DOR_POS         0
`define MFIO_DSR_POS         8
`define MFIO_CCR_POS         16
`define MFIO_DOR_GATE_BIT    3
`define MFIO_DOR_MOTOR_POS   4

// command parameter fields
`define MFIO_MODE_PRM_POS    0
`define MFIO_CONF_PRM_POS    8
`define MFIO_LOCK_PRM_POS    16

// reset values
`define MFIO_DOR_RST         8'h00
`define MFIO_DSR_RST         8'h02
`define MFIO_CCR_RST         8'h02
`define MFIO_MODE_PRM_RST    8'h00
`define MFIO_CONF_PRM_RST    8'h00
`define MFIO_LOCK_PRM_RST    1'h0
`define MFIO_SYS_MODE_RST    2'h0

// interrupt status bits
`define MFIO_EV_DISK_DONE    0
`define MFIO_EV_DISK_DATA    1
`define MFIO_EV_SER0         2
`define MFIO_EV_SER1         3
`define MFIO_EV_PAR_ACK      4
`define MFIO_EV_W            5

`endif

//--- verilog/mfio_pkg.sv
// Purpose: types shared by the interrupt output block
// Assumes: nothing
// Notes:   no constants here, see mfio_map.svh
package mfio_pkg;

  typedef enum logic [1:0] {
    MFIO_SYS_AT,
    MFIO_SYS_REDUCED,
    MFIO_SYS_ENHANCED
  } mfio_sys_mode_t;

  typedef enum logic [1:0] {
    MFIO_DISK_IDLE,
    MFIO_DISK_EXEC,
    MFIO_DISK_RESULT
  } mfio_disk_state_t;

  // field order follows the control byte: com [6:5], out2 [4], ier [3:0]
  typedef struct packed {
    logic [1:0] com;
    logic       out2;
    logic [3:0] serial_int_enable_reg;
  } mfio_ser_chan_t;

  typedef struct packed {
    logic       irq_en;
    logic [1:0] base_sel;
    logic       xt_mode;
  } mfio_par_cfg_t;

  // com 0..3 stands for the first..fourth port; 2nd/4th use line 0
  function automatic logic mfio_ser_line(input logic [1:0] com);
    mfio_ser_line = (com == 2'h1 || com == 2'h3) ? 1'b0 : 1'b1;
  endfunction : mfio_ser_line

endpackage : mfio_pkg

//--- verilog/mfio_ser_route.sv
// Purpose: steers two serial channel interrupts onto two lines
// Assumes: pending bits are levels cleared by the channel's service
// Notes:   combinational; the top registers the result
`timescale 1ns/100ps
`default_nettype none

module mfio_ser_route (
  // channel setup
  input  wire mfio_pkg::mfio_ser_chan_t chan [2],
  input  wire logic [3:0]               pend [2],
  // line results
  output logic [1:0]                    line,
  output logic [1:0]                    oe_n
);

  always_comb begin
    logic act;
    act  = 1'b0;
    line = 2'b00;
    oe_n = 2'b11;
    for (int c = 0; c < 2; c++) begin
      act = |(chan[c].serial_int_enable_reg & pend[c]) & chan[c].out2;
      if (mfio_pkg::mfio_ser_line(chan[c].com)) begin
        line[1] = line[1] | act;
        if (chan[c].out2) oe_n[1] = 1'b0;
      end else begin
        line[0] = line[0] | act;
        if (chan[c].out2) oe_n[0] = 1'b0;
      end
    end
  end

endmodule : mfio_ser_route

`default_nettype wire

//--- verilog/mfio_par_route.sv
// Purpose: selects the parallel interrupt line from the port base
// Assumes: base_sel 2 means the base that owns the low line
// Notes:   combinational; the top registers the result
`timescale 1ns/100ps
`default_nettype none

module mfio_par_route (
  // setup and printer input
  input  wire mfio_pkg::mfio_par_cfg_t cfg,
  input  wire logic                    ack_level,
  // lines, index 0 low, 1 high
  output logic [1:0]                   line,
  output logic [1:0]                   oe_n
);

  logic use_low;

  always_comb begin
    use_low = (cfg.base_sel == 2'h2);
    line    = 2'b00;
    oe_n    = 2'b11;
    if (cfg.irq_en) begin
      if (use_low) begin
        if (!cfg.xt_mode) begin
          line[0] = ack_level;
          oe_n[0] = 1'b0;
        end
      end else begin
        line[1] = ack_level;
        oe_n[1] = 1'b0;
      end
    end
  end

endmodule : mfio_par_route

`default_nettype wire

//--- verilog/mfio_top.sv
// Purpose: interrupt outputs and master reset effects of a combo chip
// Assumes: avalon-mm slave with waitrequest, one clock at 50 MHz
// Notes:   interrupt, disk and readdata pins registered, waitrequest and irq not; tristate shown as out plus oe_n
`timescale 1ns/100ps
`default_nettype none
`include "mfio_map.svh"

module mfio_top (
  // clock and reset
  input  wire  logic        clock,
  input  wire  logic        rst,
  input  wire  logic        master_reset_in,
  // avalon-mm slave
  input  wire  logic [3:0]  address,
  input  wire  logic        read,
  input  wire  logic        write,
  input  wire  logic [31:0] writedata,
  output logic [31:0]       readdata,
  output logic              waitrequest,
  // serial channel pending sources
  input  wire  logic [3:0]  ser0_pend,
  input  wire  logic [3:0]  ser1_pend,
  // printer acknowledge pin
  input  wire  logic        printer_ack_n,
  // disk controller core
  input  wire  logic        disk_cmd_start,
  input  wire  logic        disk_exec_done,
  input  wire  logic        disk_result_read,
  input  wire  logic        disk_data_ready,
  input  wire  logic        disk_nondma,
  // interrupt pins
  output logic [1:0]        serial_int_lines,
  output logic [1:0]        serial_int_oe_n,
  output logic              parallel_int_line_low,
  output logic              parallel_int_low_oe_n,
  output logic              parallel_int_line_high,
  output logic              parallel_int_high_oe_n,
  output logic              disk_int_line,
  output logic              disk_int_oe_n,
  // disk interface
  output logic [1:0]        motor_sel_n,
  // system interrupt
  output logic              irq
);

  logic                        mr;
  logic                        ack_r;
  logic                        wr_go;
  logic [31:0]                 ser_ctl_r;
  logic [31:0]                 par_ctl_r;
  logic [7:0]                  dor_r;
  logic [7:0]                  dsr_r;
  logic [7:0]                  ccr_r;
  logic [7:0]                  mode_prm_r;
  logic [7:0]                  conf_prm_r;
  logic                        lock_prm_r;
  mfio_pkg::mfio_sys_mode_t    sys_mode_r;
  mfio_pkg::mfio_disk_state_t  disk_st_r;
  mfio_pkg::mfio_disk_state_t  disk_st_nxt;
  logic                        disk_done_r;
  logic [`MFIO_EV_W-1:0]       int_stat_r;
  logic [`MFIO_EV_W-1:0]       int_mask_r;
  logic [`MFIO_EV_W-1:0]       ev;
  logic                        ack_d_r;
  logic                        disk_gate;
  logic                        disk_raw;
  mfio_pkg::mfio_ser_chan_t    chan [2];
  logic [3:0]                  pend [2];
  mfio_pkg::mfio_par_cfg_t     par_cfg;
  logic [1:0]                  ser_line;
  logic [1:0]                  ser_oe_n;
  logic [1:0]                  par_line;
  logic [1:0]                  par_oe_n;

  assign mr = rst | master_reset_in;

  // one wait cycle per access; read data loaded during it
  assign waitrequest = (read | write) & ~ack_r;
  assign wr_go       = write & ack_r;

  always_ff @(posedge clock) begin
    if (rst) ack_r <= 1'b0;
    else     ack_r <= (read | write) & ~ack_r;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ack_r) begin
      case (address)
        `MFIO_SER_CTL_OFS:   readdata <= ser_ctl_r;
        `MFIO_PAR_CTL_OFS:   readdata <= par_ctl_r;
        `MFIO_DISK_REG_OFS:  readdata <= {8'h00, ccr_r, dsr_r, dor_r};
        `MFIO_SYS_MODE_OFS:  readdata <= {30'h0, sys_mode_r};
        `MFIO_CMD_PARAM_OFS: readdata <= {15'h0, lock_prm_r, conf_prm_r,
                                          mode_prm_r};
        `MFIO_STATE_OFS:     readdata <= {24'h0, disk_st_r, disk_int_line,
                                          parallel_int_line_high,
                                          parallel_int_line_low,
                                          serial_int_lines, disk_done_r};
        `MFIO_INT_STAT_OFS:  readdata <= {27'h0, int_stat_r};
        `MFIO_INT_MASK_OFS:  readdata <= {27'h0, int_mask_r};
        default:             readdata <= 32'h0000_0000;
      endcase
    end
  end

  // serial and parallel setup; cleared by master reset so lines float
  always_ff @(posedge clock) begin
    if (mr) begin
      ser_ctl_r <= 32'h0000_0000;
      par_ctl_r <= 32'h0000_0000;
    end else if (wr_go) begin
      if (address == `MFIO_SER_CTL_OFS) ser_ctl_r <= writedata & 32'h7F7F;
      if (address == `MFIO_PAR_CTL_OFS) par_ctl_r <= writedata & 32'h1310;
    end
  end

  // disk side registers and command parameters
  always_ff @(posedge clock) begin
    if (mr) begin
      dor_r      <= `MFIO_DOR_RST;
      dsr_r      <= `MFIO_DSR_RST;
      ccr_r      <= `MFIO_CCR_RST;
      mode_prm_r <= `MFIO_MODE_PRM_RST;
      conf_prm_r <= `MFIO_CONF_PRM_RST;
      lock_prm_r <= `MFIO_LOCK_PRM_RST;
    end else if (wr_go) begin
      if (address == `MFIO_DISK_REG_OFS) begin
        dor_r <= writedata[`MFIO_DOR_POS +: 8];
        dsr_r <= writedata[`MFIO_DSR_POS +: 8];
        ccr_r <= writedata[`MFIO_CCR_POS +: 8];
      end
      if (address == `MFIO_CMD_PARAM_OFS) begin
        mode_prm_r <= writedata[`MFIO_MODE_PRM_POS +: 8];
        conf_prm_r <= writedata[`MFIO_CONF_PRM_POS +: 8];
        lock_prm_r <= writedata[`MFIO_LOCK_PRM_POS];
      end
    end
  end

  // system mode is a strap-like setting, kept across master reset
  always_ff @(posedge clock) begin
    if (rst) sys_mode_r <= mfio_pkg::mfio_sys_mode_t'(`MFIO_SYS_MODE_RST);
    else if (wr_go && address == `MFIO_SYS_MODE_OFS && writedata[1:0] != 2'h3)
      sys_mode_r <= mfio_pkg::mfio_sys_mode_t'(writedata[1:0]);
  end

  // disk command phase tracker
  always_comb begin
    disk_st_nxt = disk_st_r;
    case (disk_st_r)
      mfio_pkg::MFIO_DISK_IDLE:
        if (disk_cmd_start) disk_st_nxt = mfio_pkg::MFIO_DISK_EXEC;
      mfio_pkg::MFIO_DISK_EXEC:
        if (disk_exec_done) disk_st_nxt = mfio_pkg::MFIO_DISK_RESULT;
      mfio_pkg::MFIO_DISK_RESULT:
        if (disk_result_read) disk_st_nxt = mfio_pkg::MFIO_DISK_IDLE;
      default: disk_st_nxt = mfio_pkg::MFIO_DISK_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (mr) disk_st_r <= mfio_pkg::MFIO_DISK_IDLE;
    else    disk_st_r <= disk_st_nxt;
  end

  // end-of-execution flag held until the result is read
  always_ff @(posedge clock) begin
    if (mr)
      disk_done_r <= 1'b0;
    else if (disk_st_r == mfio_pkg::MFIO_DISK_EXEC && disk_exec_done)
      disk_done_r <= 1'b1;
    else if (disk_result_read)
      disk_done_r <= 1'b0;
  end

  assign disk_gate = (sys_mode_r == mfio_pkg::MFIO_SYS_ENHANCED) ||
                     dor_r[`MFIO_DOR_GATE_BIT];
  assign disk_raw  = disk_done_r | (disk_data_ready & disk_nondma);

  // channel setup unpacked for the steering modules
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      chan[c] = ser_ctl_r[c*`MFIO_SER_CH_STRIDE +: 7];
    end
    pend[0]          = ser0_pend;
    pend[1]          = ser1_pend;
    par_cfg.irq_en   = par_ctl_r[`MFIO_PAR_IRQEN_POS];
    par_cfg.base_sel = par_ctl_r[`MFIO_PAR_BASE_POS +: 2];
    par_cfg.xt_mode  = par_ctl_r[`MFIO_PAR_XT_POS];
  end

  mfio_ser_route u_ser (
    .chan (chan),
    .pend (pend),
    .line (ser_line),
    .oe_n (ser_oe_n)
  );

  mfio_par_route u_par (
    .cfg       (par_cfg),
    .ack_level (printer_ack_n),
    .line      (par_line),
    .oe_n      (par_oe_n)
  );

  // pins registered so they never glitch on the system bus
  always_ff @(posedge clock) begin
    if (mr) begin
      serial_int_lines       <= 2'b00;
      serial_int_oe_n        <= 2'b11;
      parallel_int_line_low  <= 1'b0;
      parallel_int_low_oe_n  <= 1'b1;
      parallel_int_line_high <= 1'b0;
      parallel_int_high_oe_n <= 1'b1;
      disk_int_line          <= 1'b0;
      disk_int_oe_n          <= 1'b0;
      motor_sel_n            <= 2'b11;
    end else begin
      serial_int_lines       <= ser_line;
      serial_int_oe_n        <= ser_oe_n;
      parallel_int_line_low  <= par_line[0];
      parallel_int_low_oe_n  <= par_oe_n[0];
      parallel_int_line_high <= par_line[1];
      parallel_int_high_oe_n <= par_oe_n[1];
      disk_int_line          <= disk_raw & disk_gate;
      disk_int_oe_n          <= 1'b0;
      motor_sel_n            <= ~dor_r[`MFIO_DOR_MOTOR_POS +: 2];
    end
  end

  // events: disk exec end, data-ready level, rising serial lines and printer acknowledge going low
  always_ff @(posedge clock) begin
    if (rst) ack_d_r <= 1'b1;
    else     ack_d_r <= printer_ack_n;
  end

  always_comb begin
    ev = '0;
    ev[`MFIO_EV_DISK_DONE] = disk_st_r == mfio_pkg::MFIO_DISK_EXEC &&
                             disk_exec_done;
    ev[`MFIO_EV_DISK_DATA] = disk_data_ready & disk_nondma;
    ev[`MFIO_EV_SER0]      = ser_line[0] & ~serial_int_lines[0];
    ev[`MFIO_EV_SER1]      = ser_line[1] & ~serial_int_lines[1];
    ev[`MFIO_EV_PAR_ACK]   = ack_d_r & ~printer_ack_n;
  end

  // set beats a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (mr) int_stat_r <= '0;
    else if (wr_go && address == `MFIO_INT_STAT_OFS)
      int_stat_r <= (int_stat_r & ~writedata[`MFIO_EV_W-1:0]) | ev;
    else
      int_stat_r <= int_stat_r | ev;
  end

  always_ff @(posedge clock) begin
    if (mr) int_mask_r <= '0;
    else if (wr_go && address == `MFIO_INT_MASK_OFS)
      int_mask_r <= writedata[`MFIO_EV_W-1:0];
  end

  assign irq = |(int_stat_r & int_mask_r);

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  chk_ser_line_cause: assert property (
    serial_int_lines[0] |->
      $past(ser_line[0]) && !$past(mr))
    else $error("serial line high without enabled pending source");
  chk_ser_route: assert property (
    (ser_ctl_r[6:5] == 2'h1 && ser_ctl_r[4] && (ser_ctl_r[3:0] & ser0_pend)
     != 4'h0 && !mr) |=> serial_int_lines[0])
    else $error("second port channel not routed to lower line");
  chk_ser_float: assert property (
    (ser_ctl_r[4] == 1'b0 && ser_ctl_r[12] == 1'b0) |=>
      serial_int_oe_n == 2'b11)
    else $error("serial line driven with out2 clear");
  chk_ser_disable: assert property (
    (ser_ctl_r[3:0] == 4'h0 && ser_ctl_r[11:8] == 4'h0) |=>
      serial_int_lines == 2'b00)
    else $error("serial line high while all sources disabled");
  chk_par_follow: assert property (
    (!parallel_int_high_oe_n && !$past(mr)) |->
      parallel_int_line_high == $past(printer_ack_n))
    else $error("parallel line does not follow acknowledge");
  chk_par_xt: assert property (
    (par_ctl_r[`MFIO_PAR_XT_POS] || !par_ctl_r[`MFIO_PAR_IRQEN_POS]) |=>
      parallel_int_low_oe_n)
    else $error("low parallel line driven in xt mode or disabled");
  chk_par_select: assert property (
    !(parallel_int_low_oe_n == 1'b0 && parallel_int_high_oe_n == 1'b0))
    else $error("both parallel lines driven");
  chk_disk_gate: assert property (
    (sys_mode_r != mfio_pkg::MFIO_SYS_ENHANCED && !dor_r[3]) |=>
      !disk_int_line || $past(sys_mode_r) == mfio_pkg::MFIO_SYS_ENHANCED
      || $past(dor_r[3]))
    else $error("disk interrupt passed with gate bit clear");
  chk_disk_done: assert property (
    (disk_st_r == mfio_pkg::MFIO_DISK_EXEC && disk_exec_done && disk_gate
     && !mr && !disk_result_read) ##1 !mr |=> disk_int_line)
    else $error("disk interrupt missing after execution end");
  chk_mr_idle: assert property (
    master_reset_in |=> disk_st_r == mfio_pkg::MFIO_DISK_IDLE &&
      motor_sel_n == 2'b11 && !disk_int_line)
    else $error("master reset left disk side active");
  chk_mr_regs: assert property (
    master_reset_in |=> dor_r == `MFIO_DOR_RST && dsr_r == `MFIO_DSR_RST &&
      ccr_r == `MFIO_CCR_RST && lock_prm_r == `MFIO_LOCK_PRM_RST)
    else $error("master reset did not restore disk registers");

  cov_ser_high:  cover property (serial_int_lines[0] ##1 !serial_int_lines[0]);
  cov_par_low:   cover property (!parallel_int_low_oe_n &&
                                 parallel_int_line_low);
  cov_disk_irq:  cover property (disk_int_line && irq);

endmodule : mfio_top

`default_nettype wire

//--- verilog/mfio_top_end.sv
// Purpose: closing file of the design set
// Assumes: read after the other design files
// Notes:   holds no code, only restores the net default
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- tb/mfio_irq_sink.sv
// Purpose: host interrupt controller side of the four shared lines
// Assumes: no pull resistor on the lines
// Notes:   a floated line shows the inverse of its last driven level
`timescale 1ns/100ps
`default_nettype none

module mfio_irq_sink (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // pin values and enables, low enable drives
  input  wire logic [3:0] drv,
  input  wire logic [3:0] oe_n,
  // levels the controller sees
  output logic      [3:0] wire_lvl
);
  logic [3:0] last_r;

  // no pull resistor, so a stale level must never look valid
  always_ff @(posedge clock) begin
    if (rst) begin
      last_r <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!oe_n[i]) last_r[i] <= drv[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wire_lvl[i] = oe_n[i] ? ~last_r[i] : drv[i];
    end
  end
endmodule : mfio_irq_sink

`default_nettype wire

//--- tb/tb_multi_function_interrupt_outputs.sv
// Purpose: self-checking bench of the interrupt output block
// Assumes: two-cycle bus access, pins settle within three edges
// Notes:   driver queues notes, negedge monitor compares them
`timescale 1ns/100ps
`default_nettype none
`include "mfio_map.svh"

module tb_multi_function_interrupt_outputs;
  typedef struct {
    int          kind;
    logic [31:0] exp;
  } mfio_note_t;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        mr = 1'b0;
  logic [3:0]  address = 4'h0;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic [31:0] rd_cap;
  logic        waitrequest;
  logic [3:0]  pend [2] = '{4'h0, 4'h0};
  logic        ack_n = 1'b1;
  logic        cmd_start = 1'b0;
  logic        exec_done = 1'b0;
  logic        res_rd = 1'b0;
  logic        data_rdy = 1'b0;
  logic        nondma = 1'b0;
  logic [1:0]  ser_ln;
  logic [1:0]  ser_oe_n;
  logic        par_lo;
  logic        par_lo_oe_n;
  logic        par_hi;
  logic        par_hi_oe_n;
  logic        disk_ln;
  logic        disk_oe_n;
  logic [1:0]  motor_sel_n;
  logic        irq;
  logic [3:0]  oe_v;
  logic [3:0]  wire_lvl;
  logic [15:0] lf = 16'hBF52;
  int          n_errors = 0;
  int          compares = 0;
  mfio_note_t  notes[$];
  string       nm [6] = '{"readdata", "serial", "parallel", "disk",
                          "motor", "irq"};

  always #10 clock = ~clock;

  assign oe_v = {par_hi_oe_n, par_lo_oe_n, ser_oe_n};

  mfio_top mfio_top_i (
    .clock(clock), .rst(rst), .master_reset_in(mr),
    .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest),
    .ser0_pend(pend[0]), .ser1_pend(pend[1]), .printer_ack_n(ack_n),
    .disk_cmd_start(cmd_start), .disk_exec_done(exec_done),
    .disk_result_read(res_rd), .disk_data_ready(data_rdy),
    .disk_nondma(nondma), .serial_int_lines(ser_ln),
    .serial_int_oe_n(ser_oe_n), .parallel_int_line_low(par_lo),
    .parallel_int_low_oe_n(par_lo_oe_n), .parallel_int_line_high(par_hi),
    .parallel_int_high_oe_n(par_hi_oe_n), .disk_int_line(disk_ln),
    .disk_int_oe_n(disk_oe_n), .motor_sel_n(motor_sel_n), .irq(irq)
  );

  mfio_irq_sink mfio_irq_sink_i (
    .clock(clock), .rst(rst), .drv({par_hi, par_lo, ser_ln}),
    .oe_n(oe_v),
    .wire_lvl(wire_lvl)
  );

  task automatic end_of_test;
    if (n_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // undriven lines read as 0, their enable tells the rest
  function automatic logic [31:0] seen(input int k);
    logic [3:0] v;
    v = wire_lvl & ~oe_v;
    case (k)
      0: seen = rd_cap;
      1: seen = {28'h0, v[1:0], oe_v[1:0]};
      2: seen = {28'h0, v[3:2], oe_v[3:2]};
      3: seen = {30'h0, disk_ln, disk_oe_n};
      4: seen = {30'h0, motor_sel_n};
      default: seen = {31'h0, irq};
    endcase
  endfunction : seen

  always @(negedge clock) begin : mon
    mfio_note_t n;
    while (notes.size() > 0) begin
      n = notes.pop_front();
      check(nm[n.kind], seen(n.kind), n.exp);
    end
  end

  task automatic note(input int k, input logic [31:0] e);
    notes.push_back('{k, e});
  endtask : note

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      n_errors++;
      end_of_test();
    end
    rd_cap = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    note(0, e);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge clock);
  endtask : settle

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic step;
    lf = lfsr(lf);
  endtask : step

  function automatic logic [31:0] scw(int c, int m, logic o,
                                      logic [3:0] ie);
    scw = {25'h0, 2'(m), o, ie} << (8 * c);
  endfunction : scw

  initial begin
    logic [3:0] serial_int_enable_reg;
    logic [3:0] p;
    logic [1:0] ln;
    logic       lo;
    logic       hi;
    logic       ak;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    settle();
    note(1, 32'h3);
    note(2, 32'h3);
    note(4, 32'h3);
    rd(`MFIO_INT_MASK_OFS, 32'h0);
    for (int c = 0; c < 2; c++) begin
      for (int m = 0; m < 4; m++) begin
        step();
        serial_int_enable_reg = lf[3:0] | 4'h1;
        p = serial_int_enable_reg & (lf[7:4] | 4'h1);
        ln = (m == 1 || m == 3) ? 2'h1 : 2'h2;
        wr(`MFIO_SER_CTL_OFS, scw(c, m, 1'b1, serial_int_enable_reg));
        pend[c] <= p;
        settle();
        note(1, {ln, ~ln});
        pend[c] <= 4'h0;
        settle();
        note(1, {2'h0, ~ln});
        pend[c] <= ~serial_int_enable_reg;
        settle();
        note(1, {2'h0, ~ln});
        pend[c] <= p;
        wr(`MFIO_SER_CTL_OFS, scw(c, m, 1'b1, 4'h0));
        settle();
        note(1, {2'h0, ~ln});
        wr(`MFIO_SER_CTL_OFS, scw(c, m, 1'b0, serial_int_enable_reg));
        settle();
        note(1, 32'h3);
        pend[c] <= 4'h0;
      end
    end
    for (int i = 0; i < 16; i++) begin
      step();
      ak = lf[0];
      ack_n <= ak;
      wr(`MFIO_PAR_CTL_OFS, {19'h0, i[3], 2'h0, i[1:0], 3'h0, i[2], 4'h0});
      lo = i[2] && i[1:0] == 2'h2 && !i[3];
      hi = i[2] && i[1:0] != 2'h2;
      settle();
      note(2, {hi&ak, lo&ak, ~hi, ~lo});
    end
    wr(`MFIO_CMD_PARAM_OFS, 32'h1FFFF);
    for (int i = 0; i < 12; i++) begin
      step();
      wr(`MFIO_SYS_MODE_OFS, 32'(i / 4));
      wr(`MFIO_DISK_REG_OFS, {16'h0, lf[15:8], 2'h0, lf[5:4], i[0], 3'h0});
      settle();
      note(4, {30'h0, ~lf[5:4]});
      if (i[1]) begin
        nondma <= 1'b1;
        data_rdy <= 1'b1;
      end else begin
        cmd_start <= 1'b1;
        @(posedge clock);
        cmd_start <= 1'b0;
        exec_done <= 1'b1;
        @(posedge clock);
        exec_done <= 1'b0;
      end
      settle();
      note(3, {(i / 4 == 2) | i[0], 1'b0});
      if (!i[1]) begin
        res_rd <= 1'b1;
        @(posedge clock);
        res_rd <= 1'b0;
        settle();
        note(3, 32'h0);
      end
      nondma <= 1'b0;
      data_rdy <= 1'b0;
      mr <= 1'b1;
      @(posedge clock);
      mr <= 1'b0;
      settle();
      note(3, 32'h0);
      note(4, 32'h3);
      rd(`MFIO_STATE_OFS, 32'h0);
      rd(`MFIO_DISK_REG_OFS, 32'h00020200);
      rd(`MFIO_SYS_MODE_OFS, 32'(i / 4));
    end
    rd(`MFIO_CMD_PARAM_OFS, 32'h0);
    wr(`MFIO_SYS_MODE_OFS, 32'h3);
    rd(`MFIO_SYS_MODE_OFS, 32'h2);
    wr(4'h9, 32'hFFFFFFFF);
    rd(4'h9, 32'h0);
    ack_n <= 1'b1;
    wr(`MFIO_PAR_CTL_OFS, 32'h10);
    wr(`MFIO_INT_STAT_OFS, 32'h3F);
    rd(`MFIO_INT_STAT_OFS, 32'h0);
    ack_n <= 1'b0;
    settle();
    rd(`MFIO_INT_STAT_OFS, 32'h10);
    note(5, 32'h0);
    wr(`MFIO_INT_MASK_OFS, 32'h10);
    settle();
    note(5, 32'h1);
    wr(`MFIO_INT_STAT_OFS, 32'h10);
    settle();
    note(5, 32'h0);
    rd(`MFIO_INT_MASK_OFS, 32'h10);
    repeat (2) @(posedge clock);
    end_of_test();
  end
endmodule : tb_multi_function_interrupt_outputs

`default_nettype wire
